/* hdl/aol_level_select.sv */
/*
 * analog output level selector: holds voltage and current levels, picks the
 * code sent to the analog driver after power-up, on target loss and sync loss.
 * assumes meas and sync_pulse are one-cycle pulses synchronous to clk_sys,
 * and that the ranging engine delivers the endpoint-relative fraction.
 */
// Overview of operation
// - voltage high 0.1..10 V, 50 mV, default 10
// - voltage high accepted only one volt above low
// - teach commands load 5 V or 10 V high
// - voltage low 0..9.9 V, 50 mV, default 0
// - either teach command sets voltage low 0 V
// - voltage at endpoints equals high or low
// - current at endpoints equals high or low
// - current high 2.2..20 mA, 0.1 mA, default 20
// - current high accepted only 2 mA above low
// - current low 2..19.9 mA, default 4 mA
// - power-up voltage level until first measurement
// - power-up current level until first measurement
// - no-target voltage low, high or hold
// - no-target current low, high or hold
// - no-target delay 5 ms units, default zero
// - follower without sync: voltage low, high, hold
// - follower without sync: current low, high, hold
// - one no-sync delay for all outputs
// - shared settings apply to both outputs alike
// - linear scaling between the endpoints
// - both outputs share one slope direction
`timescale 1ns/1ns
module aol_level_select #(
	parameter int TICK_CYCLES = aol_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                resetn,
	// avalon-mm slave
	input  wire logic [5:0]          address,
	input  wire logic                read,
	input  wire logic                write,
	input  wire logic [31:0]         writedata,
	output logic      [31:0]         readdata,
	output logic                     waitrequest,
	// measurement and sync events
	input  wire aol_pkg::aol_meas_s  meas,
	input  wire logic                sync_pulse,
	// pushbutton teach commands
	input  wire logic                teach_half_scale_voltage,
	input  wire logic                teach_full_scale_voltage,
	// analog driver codes
	output aol_pkg::aol_codes_s      codes
);
	import aol_pkg::*;

	logic                wr_fire;
	logic                rd_take;
	logic [10:0]         mode;
	logic [DLY_W-1:0]    nt_dly;
	logic [DLY_W-1:0]    ns_dly;
	logic [7:0]          lvl_hi [2];
	logic [7:0]          lvl_lo [2];
	logic [7:0]          code   [2];
	logic [7:0]          pu_code [2];
	logic                rej    [2];
	aol_act_e            act_nt [2];
	aol_act_e            act_ns [2];
	logic                reject;
	logic                teach_half;
	logic                teach_full;
	aol_phase_e          phase;
	logic [16:0]         tick_cnt;
	logic                tick;
	logic                absent;
	logic [DLY_W-1:0]    nt_cnt;
	logic [DLY_W-1:0]    ns_cnt;
	logic                nt_exp;
	logic                ns_exp;
	logic                meas_hit;

	// bus handshake: one wait cycle, then the request completes
	assign wr_fire = write && !waitrequest;
	assign rd_take = read && waitrequest;

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			waitrequest <= 1'b1;
		end else begin
			waitrequest <= !((read || write) && waitrequest);
		end
	end

	// mode and delay registers, shared by both outputs
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			mode   <= MODE_RST;
			nt_dly <= NT_DLY_RST;
			ns_dly <= NS_DLY_RST;
		end else if (wr_fire) begin
			if (address[5:2] == OFF_MODE[5:2]) begin
				mode <= writedata[10:0];
			end
			if (address[5:2] == OFF_NT_DLY[5:2]) begin
				nt_dly <= writedata[DLY_W-1:0];
			end
			if (address[5:2] == OFF_NS_DLY[5:2]) begin
				ns_dly <= writedata[DLY_W-1:0];
			end
		end
	end

	// teach from pushbutton decode or from the teach register
	assign teach_half = teach_half_scale_voltage ||
		(wr_fire && address[5:2] == OFF_TEACH[5:2] && writedata[0]);
	assign teach_full = teach_full_scale_voltage ||
		(wr_fire && address[5:2] == OFF_TEACH[5:2] && writedata[1]);

	// measurement that carries a target
	assign meas_hit = meas.valid && meas.target;

	// power-up phase ends with the first completed measurement
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			phase <= AOL_PH_POWERUP;
		end else begin
			case (phase)
				AOL_PH_POWERUP: begin
					if (meas.valid) begin
						phase <= AOL_PH_RUN;
					end
				end
				AOL_PH_RUN: phase <= AOL_PH_RUN;
				default:    phase <= AOL_PH_POWERUP;
			endcase
		end
	end

	// 5 ms tick divider
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			tick_cnt <= 17'h00000;
			tick     <= 1'b0;
		end else if (tick_cnt == 17'(TICK_CYCLES - 1)) begin
			tick_cnt <= 17'h00000;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 17'h00001;
			tick     <= 1'b0;
		end
	end

	// no-target timer counts continuous absence in ticks
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			absent <= 1'b0;
			nt_cnt <= 16'h0000;
		end else if (meas_hit) begin
			absent <= 1'b0;
			nt_cnt <= 16'h0000;
		end else begin
			if (meas.valid) begin
				absent <= 1'b1;
			end
			if (absent && tick && nt_cnt != 16'hFFFF) begin
				nt_cnt <= nt_cnt + 16'h0001;
			end
		end
	end

	// no-sync timer counts ticks since the last leader sync
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			ns_cnt <= 16'h0000;
		end else if (sync_pulse) begin
			ns_cnt <= 16'h0000;
		end else if (tick && ns_cnt != 16'hFFFF) begin
			ns_cnt <= ns_cnt + 16'h0001;
		end
	end

	// expiry, withdrawn at once when the cause returns
	assign nt_exp = absent && (nt_cnt >= nt_dly) && !meas_hit;
	assign ns_exp = mode[MODE_FOLLOW] && (ns_cnt > ns_dly) && !sync_pulse;

	// per-channel levels and output code, 0 voltage, 1 current
	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		logic [7:0]  wv;
		logic        hi_sel;
		logic        lo_sel;
		logic        hi_ok;
		logic        lo_ok;
		logic [7:0]  diff;
		logic [15:0] prod;
		logic [7:0]  scaled;
		logic [7:0]  pu_lvl;

		assign wv     = writedata[7:0];
		assign hi_sel = wr_fire && address[5:2] == 4'(2 * ch);
		assign lo_sel = wr_fire && address[5:2] == 4'(2 * ch + 1);
		// range and separation checks
		assign hi_ok = (writedata[31:8] == 24'h000000) && wv >= HI_MIN[ch] &&
			wv <= HI_MAX[ch] && {1'b0, wv} >= {1'b0, lvl_lo[ch]} + {1'b0, SEP[ch]};
		assign lo_ok = (writedata[31:8] == 24'h000000) && wv >= LO_MIN[ch] &&
			wv <= LO_MAX[ch] && {1'b0, wv} + {1'b0, SEP[ch]} <= {1'b0, lvl_hi[ch]};
		assign rej[ch] = (hi_sel && !hi_ok) || (lo_sel && !lo_ok);

		// actions from the shared mode register
		assign act_nt[ch] = aol_act_e'(mode[MODE_NT + 2 * ch +: 2]);
		assign act_ns[ch] = aol_act_e'(mode[MODE_NS + 2 * ch +: 2]);
		assign pu_lvl = mode[MODE_PU + ch] ? lvl_hi[ch] : lvl_lo[ch];
		assign pu_code[ch] = pu_lvl;

		// linear interpolation, same fraction for both outputs
		assign diff   = lvl_hi[ch] - lvl_lo[ch];
		assign prod   = diff * meas.frac;
		assign scaled = lvl_lo[ch] + prod[15:8];

		// level registers; teach touches only the voltage channel
		always_ff @(posedge clk_sys) begin
			if (!resetn) begin
				lvl_hi[ch] <= HI_RST[ch];
				lvl_lo[ch] <= LO_RST[ch];
			end else if (ch == 0 && teach_half) begin
				lvl_hi[ch] <= TEACH_HALF_V;
				lvl_lo[ch] <= TEACH_LOW_V;
			end else if (ch == 0 && teach_full) begin
				lvl_hi[ch] <= TEACH_FULL_V;
				lvl_lo[ch] <= TEACH_LOW_V;
			end else begin
				if (hi_sel && hi_ok) begin
					lvl_hi[ch] <= wv;
				end
				if (lo_sel && lo_ok) begin
					lvl_lo[ch] <= wv;
				end
			end
		end

		// output code: power-up, sync loss, target loss, scaled, hold
		always_ff @(posedge clk_sys) begin
			if (!resetn) begin
				code[ch] <= LO_RST[ch];
			end else if (phase == AOL_PH_POWERUP && !meas.valid) begin
				code[ch] <= pu_lvl;
			end else if (ns_exp && act_ns[ch] == AOL_ACT_LOW) begin
				code[ch] <= lvl_lo[ch];
			end else if (ns_exp && act_ns[ch] == AOL_ACT_HIGH) begin
				code[ch] <= lvl_hi[ch];
			end else if (ns_exp) begin
				code[ch] <= code[ch];
			end else if (nt_exp && act_nt[ch] == AOL_ACT_LOW) begin
				code[ch] <= lvl_lo[ch];
			end else if (nt_exp && act_nt[ch] == AOL_ACT_HIGH) begin
				code[ch] <= lvl_hi[ch];
			end else if (meas_hit && meas.beyond_hi) begin
				code[ch] <= lvl_hi[ch];
			end else if (meas_hit && meas.beyond_lo) begin
				code[ch] <= lvl_lo[ch];
			end else if (meas_hit) begin
				code[ch] <= scaled;
			end
		end
	end

	// sticky reject flag, write one to clear; a new reject wins
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			reject <= 1'b0;
		end else if (rej[0] || rej[1]) begin
			reject <= 1'b1;
		end else if (wr_fire && address[5:2] == OFF_STATUS[5:2] && writedata[STAT_REJECT]) begin
			reject <= 1'b0;
		end
	end

	// read data, captured in the wait cycle; unmapped reads as zero
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			readdata <= 32'h00000000;
		end else if (rd_take) begin
			case (address[5:2])
				OFF_V_HIGH[5:2]: readdata <= {24'h000000, lvl_hi[0]};
				OFF_V_LOW[5:2]:  readdata <= {24'h000000, lvl_lo[0]};
				OFF_I_HIGH[5:2]: readdata <= {24'h000000, lvl_hi[1]};
				OFF_I_LOW[5:2]:  readdata <= {24'h000000, lvl_lo[1]};
				OFF_MODE[5:2]:   readdata <= {21'h000000, mode};
				OFF_NT_DLY[5:2]: readdata <= {16'h0000, nt_dly};
				OFF_NS_DLY[5:2]: readdata <= {16'h0000, ns_dly};
				OFF_STATUS[5:2]: readdata <= {28'h0000000, ns_exp, nt_exp,
					phase == AOL_PH_RUN, reject};
				OFF_CODES[5:2]:  readdata <= {8'h00, code[1], 8'h00, code[0]};
				default:         readdata <= 32'h00000000;
			endcase
		end
	end

	// codes straight from the code flops
	assign codes = {code[1], code[0]};

	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	property p_v_range;
		lvl_hi[0] >= HI_MIN[0] && lvl_hi[0] <= HI_MAX[0] && lvl_lo[0] <= LO_MAX[0];
	endproperty
	a_v_range: assert property (p_v_range) else $error("voltage level out of range");

	property p_v_sep;
		{1'b0, lvl_hi[0]} >= {1'b0, lvl_lo[0]} + 9'h014;
	endproperty
	a_v_sep: assert property (p_v_sep) else $error("voltage levels too close");

	property p_teach_half;
		teach_half |=> lvl_hi[0] == 8'h64 && lvl_lo[0] == 8'h00;
	endproperty
	a_teach_half: assert property (p_teach_half) else $error("half teach not loaded");

	property p_teach_full;
		teach_full && !teach_half |=> lvl_hi[0] == 8'hC8 && lvl_lo[0] == 8'h00;
	endproperty
	a_teach_full: assert property (p_teach_full) else $error("full teach not loaded");

	property p_i_sep;
		{1'b0, lvl_hi[1]} >= {1'b0, lvl_lo[1]} + 9'h014 && lvl_lo[1] >= 8'h14;
	endproperty
	a_i_sep: assert property (p_i_sep) else $error("current levels invalid");

	property p_i_range;
		lvl_hi[1] >= HI_MIN[1] && lvl_hi[1] <= HI_MAX[1] &&
			lvl_lo[1] >= LO_MIN[1] && lvl_lo[1] <= LO_MAX[1];
	endproperty
	a_i_range: assert property (p_i_range) else $error("current level out of range");

	property p_powerup;
		phase == AOL_PH_POWERUP && !meas.valid |=>
			code[0] == $past(pu_code[0]) &&
			code[1] == $past(pu_code[1]);
	endproperty
	a_powerup: assert property (p_powerup) else $error("power-up level wrong");

	property p_beyond_hi;
		phase == AOL_PH_RUN && meas_hit && meas.beyond_hi && !ns_exp |=>
			code[0] == $past(lvl_hi[0]) && code[1] == $past(lvl_hi[1]);
	endproperty
	a_beyond_hi: assert property (p_beyond_hi) else $error("endpoint level wrong");

	property p_nt_low;
		phase == AOL_PH_RUN && nt_exp && !ns_exp && act_nt[1] == AOL_ACT_LOW |=>
			code[1] == $past(lvl_lo[1]);
	endproperty
	a_nt_low: assert property (p_nt_low) else $error("no-target current not low");

	property p_ns_high;
		phase == AOL_PH_RUN && ns_exp && act_ns[0] == AOL_ACT_HIGH |=>
			code[0] == $past(lvl_hi[0]);
	endproperty
	a_ns_high: assert property (p_ns_high) else $error("no-sync voltage not high");

	property p_hold;
		phase == AOL_PH_RUN && !meas.valid && !nt_exp && !ns_exp |=>
			$stable(code[0]) && $stable(code[1]);
	endproperty
	a_hold: assert property (p_hold) else $error("code moved without measurement");

	property p_restart;
		meas_hit |=> nt_cnt == 16'h0000 && !absent ##1 !nt_exp || nt_dly == 16'h0000;
	endproperty
	a_restart: assert property (p_restart) else $error("no-target timer not restarted");

	c_teach: cover property (teach_half ##1 teach_full);
	c_nt:    cover property (phase == AOL_PH_RUN && nt_exp && act_nt[0] == AOL_ACT_LOW);
	c_ns:    cover property (ns_exp ##[1:5] sync_pulse);
	c_rej:   cover property (rej[0] ##1 reject);
endmodule

/* hdl/aol_pkg.sv */
/*
 * constants, encodings and carrier types for the analog output level selector.
 * assumes a 20 MHz system clock and a word-wide avalon-mm register bus.
 */
package aol_pkg;
	// code widths: voltage in 50 mV steps, current in 0.1 mA steps
	localparam int CODE_W = 8;
	localparam int DLY_W  = 16;

	// register byte offsets
	localparam logic [5:0] OFF_V_HIGH = 6'h00;
	localparam logic [5:0] OFF_V_LOW  = 6'h04;
	localparam logic [5:0] OFF_I_HIGH = 6'h08;
	localparam logic [5:0] OFF_I_LOW  = 6'h0C;
	localparam logic [5:0] OFF_MODE   = 6'h10;
	localparam logic [5:0] OFF_NT_DLY = 6'h14;
	localparam logic [5:0] OFF_NS_DLY = 6'h18;
	localparam logic [5:0] OFF_TEACH  = 6'h1C;
	localparam logic [5:0] OFF_STATUS = 6'h20;
	localparam logic [5:0] OFF_CODES  = 6'h24;

	// per-channel level limits, index 0 voltage, index 1 current
	localparam logic [1:0][7:0] HI_MIN = {8'h16, 8'h02};
	localparam logic [1:0][7:0] HI_MAX = {8'hC8, 8'hC8};
	localparam logic [1:0][7:0] LO_MIN = {8'h14, 8'h00};
	localparam logic [1:0][7:0] LO_MAX = {8'hC7, 8'hC6};
	localparam logic [1:0][7:0] HI_RST = {8'hC8, 8'hC8};
	localparam logic [1:0][7:0] LO_RST = {8'h28, 8'h00};
	localparam logic [1:0][7:0] SEP    = {8'h14, 8'h14};

	// teach values for the voltage channel
	localparam logic [7:0] TEACH_HALF_V = 8'h64;
	localparam logic [7:0] TEACH_FULL_V = 8'hC8;
	localparam logic [7:0] TEACH_LOW_V  = 8'h00;

	// mode register fields and reset values
	localparam int MODE_PU     = 0;
	localparam int MODE_NT     = 2;
	localparam int MODE_NS     = 6;
	localparam int MODE_FOLLOW = 10;
	localparam logic [10:0] MODE_RST   = 11'h000;
	localparam logic [15:0] NT_DLY_RST = 16'h0000;
	localparam logic [15:0] NS_DLY_RST = 16'h0000;

	// status bits
	localparam int STAT_REJECT = 0;
	localparam int STAT_FIRST  = 1;
	localparam int STAT_NT     = 2;
	localparam int STAT_NS     = 3;

	// delay tick: one per 5 ms
	localparam int CLK_HZ      = 20_000_000;
	localparam int TICK_MS     = 5;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

	typedef enum logic [1:0] {AOL_ACT_HOLD, AOL_ACT_LOW, AOL_ACT_HIGH, AOL_ACT_RSVD} aol_act_e;
	typedef enum logic {AOL_PH_POWERUP, AOL_PH_RUN} aol_phase_e;

	// measurement result from the ranging engine
	typedef struct packed {
		logic       valid;
		logic       target;
		logic       beyond_lo;
		logic       beyond_hi;
		logic [7:0] frac;
	} aol_meas_s;

	// codes to the analog driver stage
	typedef struct packed {
		logic [7:0] i_code;
		logic [7:0] v_code;
	} aol_codes_s;
endpackage

/* tb/aol_driver_model.sv */
/*
 * behavioural analog driver stage: turns selector codes into output levels.
 * assumes codes come straight from the selector's flops.
 */
`timescale 1ns/1ns
module aol_driver_model (
	// codes from the selector
	input  aol_pkg::aol_codes_s codes,
	// levels at the output pins
	output logic [15:0]         v_mv,
	output logic [15:0]         i_ua
);
	import aol_pkg::*;

	// 50 mV and 0.1 mA per code step
	assign v_mv = 16'(codes.v_code) * 16'h0032;
	assign i_ua = 16'(codes.i_code) * 16'h0064;
endmodule

/* tb/aol_level_select_tb.sv */
/*
 * self-checking bench for the analog output level selector.
 * assumes the driver stage model beside it and a ten-cycle delay tick.
 */
`timescale 1ns/1ns
module aol_level_select_tb;
	import aol_pkg::*;
	localparam int TK = 10;
	logic        clk_sys, resetn, read, write, waitrequest, sync_pulse;
	logic        teach_half_scale_voltage, teach_full_scale_voltage;
	logic [5:0]  address;
	logic [31:0] writedata, readdata, rd;
	aol_meas_s   meas;
	aol_codes_s  codes;
	logic [15:0] v_mv, i_ua;
	logic        ok;
	logic [7:0]  lv [4];
	logic [7:0]  bnd [8];
	logic [7:0]  f, vc, ic;
	int          fail_count = 0, total_checks = 0, a, k, x, vm, im;

	aol_level_select #(.TICK_CYCLES(TK)) i_dut (.clk_sys(clk_sys), .resetn(resetn),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .meas(meas), .sync_pulse(sync_pulse),
		.teach_half_scale_voltage(teach_half_scale_voltage),
		.teach_full_scale_voltage(teach_full_scale_voltage), .codes(codes));
	aol_driver_model i_drv (.codes(codes), .v_mv(v_mv), .i_ua(i_ua));

	// 20 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic tally_and_finish;
		if (fail_count == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [5:0] ad, input logic [31:0] wd);
		@(posedge clk_sys);
		read <= ~wr;
		write <= wr;
		address <= ad;
		writedata <= wd;
		do @(posedge clk_sys); while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic rchk(input string nm, input logic [5:0] ad, input logic [31:0] exp);
		bus(1'b0, ad, 32'h0);
		chk(nm, rd, exp);
	endtask

	task automatic ccodes(input logic [7:0] ve, input logic [7:0] ie);
		chk("v_mv", 32'(v_mv), 32'(ve) * 32'h32);
		chk("i_ua", 32'(i_ua), 32'(ie) * 32'h64);
	endtask

	// one measurement pulse; returns at the edge after the codes landed
	task automatic mpulse(input logic tg, input logic bl, input logic bh, input logic [7:0] fr);
		@(posedge clk_sys);
		meas <= {1'b1, tg, bl, bh, fr};
		@(posedge clk_sys);
		meas.valid <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic teach(input logic h);
		@(posedge clk_sys);
		teach_half_scale_voltage <= h;
		teach_full_scale_voltage <= ~h;
		@(posedge clk_sys);
		teach_half_scale_voltage <= 1'b0;
		teach_full_scale_voltage <= 1'b0;
	endtask

	task automatic spulse;
		@(posedge clk_sys);
		sync_pulse <= 1'b1;
		@(posedge clk_sys);
		sync_pulse <= 1'b0;
	endtask

	// legality of a level write: range and separation from the partner level
	function automatic logic acc(int n, int v);
		int ch;
		ch = n / 2;
		if (n % 2 == 0) return v >= HI_MIN[ch] && v <= HI_MAX[ch] && v >= lv[n+1] + SEP[ch];
		return v >= LO_MIN[ch] && v <= LO_MAX[ch] && v + SEP[ch] <= lv[n-1];
	endfunction

	// scaled code between the endpoints
	function automatic logic [7:0] scl(int ch, logic [7:0] fr);
		return lv[2*ch+1] + 8'(((int'(lv[2*ch]) - int'(lv[2*ch+1])) * int'(fr)) >>> 8);
	endfunction

	function automatic logic [7:0] act(int m, int ch, logic [7:0] c);
		return m == 1 ? lv[2*ch+1] : m == 2 ? lv[2*ch] : c;
	endfunction

	// watchdog
	initial begin
		repeat (30000) @(posedge clk_sys);
		fail_count++;
		tally_and_finish;
	end

	initial begin
		resetn <= 1'b0;
		read <= 1'b0;
		write <= 1'b0;
		address <= '0;
		writedata <= '0;
		meas <= '0;
		sync_pulse <= 1'b0;
		teach_half_scale_voltage <= 1'b0;
		teach_full_scale_voltage <= 1'b0;
		lv = '{HI_RST[0], LO_RST[0], HI_RST[1], LO_RST[1]};
		bnd = '{8'h01, 8'h00, 8'h15, 8'h13, 8'hC9, 8'hB4, 8'h3C, 8'h29};
		void'($urandom(1834));
		repeat (4) @(posedge clk_sys);
		resetn <= 1'b1;
		// reset values
		for (a = 0; a < 4; a++) rchk("level", 6'(4 * a), 32'(lv[a]));
		rchk("mode", OFF_MODE, 32'(MODE_RST));
		rchk("nt_dly", OFF_NT_DLY, 32'(NT_DLY_RST));
		rchk("ns_dly", OFF_NS_DLY, 32'(NS_DLY_RST));
		rchk("unmapped", 6'h3C, 32'h0);
		rchk("status", OFF_STATUS, 32'h0);
		ccodes(lv[1], lv[3]);
		// boundary then random level writes with the reject flag
		for (a = 0; a < 40; a++) begin
			k = a % 4;
			x = (a < 8) ? int'(bnd[a]) : $urandom_range(0, 200);
			ok = acc(k, x);
			bus(1'b1, OFF_STATUS, 32'h1);
			bus(1'b1, 6'(4 * k), 32'(x));
			bus(1'b0, OFF_STATUS, 32'h0);
			chk("accept", 32'(rd[STAT_REJECT]), 32'(!ok));
			if (ok) lv[k] = 8'(x);
			rchk("level", 6'(4 * k), 32'(lv[k]));
			bus(1'b0, OFF_STATUS, 32'h0);
			chk("reject", 32'(rd[STAT_REJECT]), 32'(lv[k] !== 8'(x)));
		end
		// upper data bits set: refused like an out-of-range level
		bus(1'b1, OFF_STATUS, 32'h1);
		bus(1'b1, OFF_V_HIGH, 32'h100 | 32'(lv[0]));
		rchk("wide", OFF_STATUS, 32'h1);
		rchk("v_high", OFF_V_HIGH, 32'(lv[0]));
		// power-up level follows the selection until the first measurement
		ccodes(lv[1], lv[3]);
		bus(1'b1, OFF_MODE, 32'h3);
		repeat (2) @(posedge clk_sys);
		ccodes(lv[0], lv[2]);
		// teach commands
		teach(1'b1);
		lv[0] = TEACH_HALF_V;
		lv[1] = TEACH_LOW_V;
		rchk("v_high", OFF_V_HIGH, 32'(lv[0]));
		rchk("v_low", OFF_V_LOW, 32'(lv[1]));
		bus(1'b1, OFF_V_LOW, 32'h14);
		teach(1'b0);
		lv[0] = TEACH_FULL_V;
		rchk("v_high", OFF_V_HIGH, 32'(lv[0]));
		rchk("v_low", OFF_V_LOW, 32'(lv[1]));
		// teach through the teach register
		bus(1'b1, OFF_TEACH, 32'h1);
		rchk("v_high", OFF_V_HIGH, 32'(TEACH_HALF_V));
		bus(1'b1, OFF_TEACH, 32'h2);
		rchk("v_high", OFF_V_HIGH, 32'(TEACH_FULL_V));
		// endpoints and linear scaling
		for (a = 0; a < 12; a++) begin
			f = (a < 2) ? 8'(255 * a) : 8'($urandom_range(0, 255));
			mpulse(1'b1, 1'b0, 1'b0, f);
			ccodes(scl(0, f), scl(1, f));
			mpulse(1'b1, 1'b0, 1'b1, f);
			ccodes(lv[0], lv[2]);
			rchk("codes", OFF_CODES, {8'h00, lv[2], 8'h00, lv[0]});
			mpulse(1'b1, 1'b1, 1'b0, f);
			ccodes(lv[1], lv[3]);
		end
		// no-target action, every code, three-tick delay
		bus(1'b1, OFF_NT_DLY, 32'h3);
		for (a = 0; a < 4; a++) begin
			bus(1'b1, OFF_MODE, 32'((a << 2) | (((a + 1) % 4) << 4)));
			f = 8'($urandom_range(0, 255));
			mpulse(1'b1, 1'b0, 1'b0, f);
			vc = scl(0, f);
			ic = scl(1, f);
			ccodes(vc, ic);
			mpulse(1'b0, 1'b0, 1'b0, f);
			repeat (15) @(posedge clk_sys);
			ccodes(vc, ic);
			repeat (20) @(posedge clk_sys);
			ccodes(act(a, 0, vc), act((a + 1) % 4, 1, ic));
			bus(1'b0, OFF_STATUS, 32'h0);
			chk("nt_state", 32'(rd[3:1]), 32'h3);
		end
		// sync follower losing the leader
		bus(1'b1, OFF_NS_DLY, 32'h2);
		for (a = 0; a < 2; a++) begin
			vm = 2 - a;
			im = (1 + 2 * a) % 3;
			bus(1'b1, OFF_MODE, 32'(32'h400 | (vm << 6) | (im << 8)));
			spulse;
			f = 8'($urandom_range(0, 255));
			mpulse(1'b1, 1'b0, 1'b0, f);
			vc = scl(0, f);
			ic = scl(1, f);
			ccodes(vc, ic);
			repeat (40) @(posedge clk_sys);
			ccodes(act(vm, 0, vc), act(im, 1, ic));
			bus(1'b0, OFF_STATUS, 32'h0);
			chk("ns_state", 32'(rd[3:1]), 32'h5);
			mpulse(1'b1, 1'b0, 1'b1, f);
			ccodes(act(vm, 0, vc), act(im, 1, ic));
		end
		tally_and_finish;
	end
endmodule
